// file: verilog/mdmia_pkg.sv
// Package: constants and types for the serial management slave
// How it works
// - Management clock may stop while bus idle
// - Data line sampled on clock rising edge
// - Answer only own strapped 4-bit address
// - Register field picks one of 32 registers
// - Frame starts with 01 after idle high
// - Read: release, drive zero, then 16 bits
// - Control at 0xd, address/data at 0xe
// - Only select codes 11111 and 00001 served
// - Other select codes: address/data access ignored
// - Control bits 15:14 choose access function
// - Address function touches pointer, not registers
// - Function 01 keeps pointer unchanged
// - Function 10 increments after reads and writes
// - Function 11 increments after writes only
package mdmia_pkg;
  localparam logic [4:0]  MDMIA_OFS_CTRL    = 5'h0d;
  localparam logic [4:0]  MDMIA_OFS_ADDDATA = 5'h0e;
  localparam logic [4:0]  MDMIA_SEL_VENDOR  = 5'h1f;
  localparam logic [4:0]  MDMIA_SEL_PMA     = 5'h01;
  localparam logic [1:0]  MDMIA_OP_READ     = 2'h2;
  localparam logic [1:0]  MDMIA_OP_WRITE    = 2'h1;
  localparam logic [15:0] MDMIA_CTRL_RST    = 16'h0000;
  localparam logic [15:0] MDMIA_PTR_RST     = 16'h0000;
  localparam int          MDMIA_FUNC_HI     = 15;
  localparam int          MDMIA_FUNC_LO     = 14;
  localparam int          MDMIA_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    MDMIA_FN_ADDR,
    MDMIA_FN_DATA,
    MDMIA_FN_INC_RW,
    MDMIA_FN_INC_WR
  } mdmia_func_t;

  // One finished register access decoded from a frame
  typedef struct packed {
    logic        wr;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
  } mdmia_req_t;
endpackage

// file: verilog/mdmia_sync.sv
// Two-flop synchroniser per bit
`timescale 1ns/1ns
module mdmia_sync
  import mdmia_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clk_in)
  begin
    meta_ff <= d_in;
    q_ff    <= meta_ff;
  end

  assign q_out = q_ff;
endmodule

// file: verilog/mdmia_ext_regs.sv
// Extended register sets behind the indirect access path
`timescale 1ns/1ns
module mdmia_ext_regs
  import mdmia_pkg::*;
#(
  parameter int DEPTH = 32
)(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Access
  input  wire logic        we_in,
  input  wire logic        set_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] rdata_out
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || DEPTH > 65536)
      $error("mdmia_ext_regs: DEPTH out of range");
  end

  logic [15:0] vend_mem [DEPTH];
  logic [15:0] pma_mem  [DEPTH];
  wire  [AW-1:0] idx = addr_in[AW-1:0];

  // Contents are kept small here; upper pointer bits alias
  always_ff @(posedge clk_in)
  begin
    if (we_in && set_in)
      pma_mem[idx] <= wdata_in;
    else if (we_in)
      vend_mem[idx] <= wdata_in;
  end

  assign rdata_out = set_in ? pma_mem[idx] : vend_mem[idx];
endmodule

// file: verilog/mdmia_top.sv
// Serial management slave with indirect extended register access
`timescale 1ns/1ns
module mdmia_top
  import mdmia_pkg::*;
#(
  parameter int EXT_DEPTH = 32
)(
  // Clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  // Address straps
  input  wire logic [3:0] PHY_BUS_ADDRESS_PINS_IN,
  // Management link
  input  wire logic       MDC_IN,
  input  wire logic       MDIO_IN,
  output logic            MDIO_OUT,
  output logic            MDIO_OE_OUT
);
  // Depth must cover two words and fit the 16-bit pointer
  initial
  begin
    if (EXT_DEPTH < 2)
      $error("mdmia_top: EXT_DEPTH too small");
    if (EXT_DEPTH > 65536)
      $error("mdmia_top: EXT_DEPTH too large");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_START, S_HDR, S_TA, S_DATA
  } mdmia_state_t;

  // Synchronise link pins and straps
  logic [5:0] sync_q;
  mdmia_sync #(.WIDTH(6)) u_sync (
    .clk_in (CLK_IN),
    .d_in   ({PHY_BUS_ADDRESS_PINS_IN, MDC_IN, MDIO_IN}),
    .q_out  (sync_q)
  );
  wire       mdc_s  = sync_q[1];
  wire       mdio_s = sync_q[0];
  wire [3:0] pins_s = sync_q[5:2];

  // Edge detect and own address
  logic         mdc_d_ff;
  logic [3:0]   phy_addr_ff;
  logic         strap_done_ff;
  // Frame decoder
  mdmia_state_t state_ff;
  logic [4:0]   cnt_ff;
  logic [13:0]  hdr_ff;
  logic [15:0]  data_ff;
  logic         hit_ff;
  // Indirect access registers
  logic [15:0]  ctrl_ff;
  logic [15:0]  ptr_ff;
  // Read drive
  logic [15:0]  rd_sh_ff;
  logic         out_ff;
  logic         oe_ff;

  // Edges found by sampling
  // A stopped clock simply yields no edges, so nothing times out
  // Rising edge samples data
  wire rise = mdc_s & ~mdc_d_ff;
  wire fall = ~mdc_s & mdc_d_ff;

  wire [1:0] f_op   = hdr_ff[11:10];
  wire [4:0] f_phy  = hdr_ff[9:5];
  wire [4:0] f_reg  = hdr_ff[4:0];
  wire       f_rd   = (f_op == MDMIA_OP_READ);
  wire       f_wr   = (f_op == MDMIA_OP_WRITE);
  wire       addr_ok = (f_phy[3:0] == phy_addr_ff) & (f_phy[4] == 1'b0);

  // Indirect path decode
  // Function field
  wire [1:0] func_w   = ctrl_ff[MDMIA_FUNC_HI:MDMIA_FUNC_LO];
  wire [4:0] sel_w    = ctrl_ff[4:0];
  wire       sel_pma  = (sel_w == MDMIA_SEL_PMA);
  wire       sel_ok   = (sel_w == MDMIA_SEL_VENDOR) | sel_pma;
  wire       is_addr  = (func_w == 2'(MDMIA_FN_ADDR));
  wire [15:0] ext_rd;

  // Completed access at end of the data field
  wire       data_last = (state_ff == S_DATA) & (cnt_ff == 5'd15);
  wire       acc_done  = rise & data_last & hit_ff;
  mdmia_req_t req;
  assign req.wr       = f_wr;
  assign req.reg_addr = f_reg;
  assign req.wdata    = {data_ff[14:0], mdio_s};
  wire       ad_acc   = acc_done & (req.reg_addr == MDMIA_OFS_ADDDATA) & sel_ok;
  wire       ext_we   = ad_acc & req.wr & ~is_addr;
  wire       ptr_wr   = ad_acc & req.wr & is_addr;
  wire       ptr_inc  = ad_acc & ~is_addr &
                        ((func_w == 2'(MDMIA_FN_INC_RW)) |
                         ((func_w == 2'(MDMIA_FN_INC_WR)) & req.wr));
  wire       ctrl_wr  = acc_done & req.wr & (req.reg_addr == MDMIA_OFS_CTRL);

  // Address path also carries the new pointer while it is written
  mdmia_ext_regs #(.DEPTH(EXT_DEPTH)) u_ext (
    .clk_in    (CLK_IN),
    .rst_in    (RST_IN),
    .we_in     (ext_we),
    .set_in    (sel_pma),
    .addr_in   (ptr_wr ? req.wdata : ptr_ff),
    .wdata_in  (req.wdata),
    .rdata_out (ext_rd)
  );

  // Read value selection for the 32 direct registers
  // Direct register select
  logic [15:0] rd_val;
  always_comb
  begin
    // Unimplemented registers read zero
    rd_val = 16'h0000;
    if (f_reg == MDMIA_OFS_CTRL)
      rd_val = ctrl_ff;
    else if (f_reg == MDMIA_OFS_ADDDATA)
    begin
      // Pointer or selected extended register
      // Ignored select reads zero
      if (!sel_ok)
        rd_val = 16'h0000;
      else if (is_addr)
        rd_val = ptr_ff;
      else
        rd_val = ext_rd;
    end
  end

  // Strap capture after reset release
  // Address latched at reset
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      strap_done_ff <= 1'b0;
    else
      strap_done_ff <= 1'b1;
  end

  always_ff @(posedge CLK_IN)
  begin
    // Latch own address once after reset
    if (!strap_done_ff)
      phy_addr_ff <= pins_s;
  end

  always_ff @(posedge CLK_IN)
  begin
    // Reset low matches an idle stopped clock, so no false edge
    if (RST_IN)
      mdc_d_ff <= 1'b0;
    else
      mdc_d_ff <= mdc_s;
  end

  // Frame sequencer
  // Frames to other devices still run the counter, keeping step
  always_ff @(posedge CLK_IN)
  begin
    // Held idle until the address is latched
    if (RST_IN || !strap_done_ff)
    begin
      state_ff <= S_IDLE;
      cnt_ff   <= 5'd0;
      hdr_ff   <= 14'h0000;
      data_ff  <= 16'h0000;
      hit_ff   <= 1'b0;
    end
    else if (rise)
    begin
      unique case (state_ff)
        S_IDLE:
        begin
          if (!mdio_s)
            state_ff <= S_START;
        end
        S_START:
        begin
          cnt_ff   <= 5'd0;
          state_ff <= mdio_s ? S_HDR : S_START;
        end
        S_HDR:
        begin
          hdr_ff <= {hdr_ff[12:0], mdio_s};
          cnt_ff <= cnt_ff + 5'd1;
          if (cnt_ff == 5'd11)
          begin
            state_ff <= S_TA;
            cnt_ff   <= 5'd0;
          end
        end
        S_TA:
        begin
          cnt_ff <= cnt_ff + 5'd1;
          if (cnt_ff == 5'd0)
            hit_ff <= addr_ok & (f_rd | f_wr);
          else
          begin
            state_ff <= S_DATA;
            cnt_ff   <= 5'd0;
          end
        end
        S_DATA:
        begin
          data_ff <= req.wdata;
          cnt_ff  <= cnt_ff + 5'd1;
          if (cnt_ff == 5'd15)
          begin
            state_ff <= S_IDLE;
            hit_ff   <= 1'b0;
          end
        end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

  // Control holds unless written
  wire [15:0] nxt_ctrl = ctrl_wr ? req.wdata : ctrl_ff;
  wire [15:0] nxt_ptr  = ptr_wr  ? req.wdata :
                         ptr_inc ? ptr_ff + 16'h0001 : ptr_ff;

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      ctrl_ff <= MDMIA_CTRL_RST;
    else
      ctrl_ff <= nxt_ctrl;
  end

  // Pointer is shared by both sets; switching set keeps it
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      ptr_ff <= MDMIA_PTR_RST;
    else
      ptr_ff <= nxt_ptr;
  end

  wire ta_drive   = (state_ff == S_TA) & (cnt_ff == 5'd1) & hit_ff & f_rd;
  wire data_drive = (state_ff == S_DATA) & oe_ff;

  // Read driver changes on falling edge so data is stable at rising edge
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      oe_ff    <= 1'b0;
      out_ff   <= 1'b1;
      rd_sh_ff <= 16'h0000;
    end
    else if (fall)
    begin
      if (ta_drive)
      begin
        oe_ff    <= 1'b1;
        out_ff   <= 1'b0;
        rd_sh_ff <= rd_val;
      end
      else if (data_drive)
      begin
        out_ff   <= rd_sh_ff[15];
        rd_sh_ff <= {rd_sh_ff[14:0], 1'b0};
      end
      else
      begin
        // Write frames and idle never drive
        oe_ff  <= 1'b0;
        out_ff <= 1'b1;
      end
    end
  end

  // Outputs come straight from flip-flops
  assign MDIO_OUT    = out_ff;
  assign MDIO_OE_OUT = oe_ff;
endmodule

// file: sim/mdmia_monitor.sv
// Checker on the management slave pins
`timescale 1ns/1ns
module mdmia_monitor
  import mdmia_pkg::*;
(
  input wire logic       CLK_IN,
  input wire logic       RST_IN,
  input wire logic [3:0] PHY_BUS_ADDRESS_PINS_IN,
  input wire logic       MDC_IN,
  input wire logic       MDIO_IN,
  input wire logic       MDIO_OUT,
  input wire logic       MDIO_OE_OUT
);
  logic [8:0] drv_ff;
  logic [5:0] idle_ff;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // Counters: drive length and stopped clock
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      drv_ff  <= 9'h000;
      idle_ff <= 6'h00;
    end
    else
    begin
      drv_ff  <= MDIO_OE_OUT ? drv_ff + 9'h001 : 9'h000;
      idle_ff <= MDC_IN ? 6'h00 : (idle_ff == 6'h3f ? idle_ff : idle_ff + 6'h01);
    end
  end
  rst_quiet_a: assert property ($fell(RST_IN) |-> !MDIO_OE_OUT && MDIO_OUT)
    else $error("line driven out of reset");
  idle_high_a: assert property (!MDIO_OE_OUT |-> MDIO_OUT)
    else $error("released drive value not high");
  ta_zero_a: assert property ($rose(MDIO_OE_OUT) |-> !MDIO_OUT)
    else $error("turnaround bit not zero");
  bit_hold_a: assert property (MDIO_OE_OUT && $changed(MDIO_OUT) |=> $stable(MDIO_OUT)[*8])
    else $error("data bit held too briefly");
  out_edge_a: assert property (MDIO_OE_OUT && $changed(MDIO_OUT) |-> !MDC_IN)
    else $error("data changed while clock high");
  oe_edge_a: assert property ($changed(MDIO_OE_OUT) |-> !MDC_IN)
    else $error("drive enable moved while clock high");
  drv_len_a: assert property ($fell(MDIO_OE_OUT) |-> drv_ff >= 9'h0a6 && drv_ff <= 9'h0ae)
    else $error("read drive not seventeen bits long");
  stop_quiet_a: assert property (idle_ff > 6'h10 |-> !MDIO_OE_OUT)
    else $error("line driven while clock stopped");
endmodule

bind mdmia_top mdmia_monitor mon (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .PHY_BUS_ADDRESS_PINS_IN(PHY_BUS_ADDRESS_PINS_IN), .MDC_IN(MDC_IN), .MDIO_IN(MDIO_IN),
  .MDIO_OUT(MDIO_OUT), .MDIO_OE_OUT(MDIO_OE_OUT));

// file: sim/mdmia_sta.sv
// Station manager model: makes the clock and frames
`timescale 1ns/1ns
module mdmia_sta
  import mdmia_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic mdio_in,
  output logic      mdc_out,
  output logic      mdio_out,
  output logic      mdio_oe_out
);
  initial
  begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_oe_out = 1'b0;
  end
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [16:0] rd);
    logic [35:0] w;
    w = {4'hf, 2'h1, op, pa, ra, 2'h2, wd};
    rd = 17'h00000;
    for (int i = 35; i >= 0; i--)
    begin
      // 80 ns period, released on read
      repeat (5) @(posedge clk_in);
      mdc_out <= 1'b0;
      mdio_oe_out <= (op != MDMIA_OP_READ) || (i > 17);
      mdio_out <= w[i];
      repeat (5) @(posedge clk_in);
      mdc_out <= 1'b1;
      rd = {rd[15:0], mdio_in};
    end
    repeat (5) @(posedge clk_in);
    mdc_out <= 1'b0;
    mdio_oe_out <= 1'b0;
    mdio_out <= 1'b1;
    repeat (20) @(posedge clk_in);
  endtask
endmodule

// file: sim/mdmia_tb.sv
// Self-checking bench for the management slave
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench
  import mdmia_pkg::*;
;
  localparam logic [4:0] own = 5'h05;
  localparam logic [4:0] c = MDMIA_OFS_CTRL;
  localparam logic [4:0] a = MDMIA_OFS_ADDDATA;
  logic       clk;
  logic       rst;
  logic [3:0] strap;
  wire        mdc;
  wire        sd;
  wire        soe;
  wire        out;
  wire        oe;
  wire        line;
  int         fail_count;
  int         compares;
  logic [16:0] junk;
  // Pull-up wins when nobody drives
  assign line = oe ? out : (soe ? sd : 1'b1);
  mdmia_top #(.EXT_DEPTH(32)) dut (.CLK_IN(clk), .RST_IN(rst), .PHY_BUS_ADDRESS_PINS_IN(strap),
    .MDC_IN(mdc), .MDIO_IN(line), .MDIO_OUT(out), .MDIO_OE_OUT(oe));
  mdmia_sta sta (.clk_in(clk), .mdio_in(line), .mdc_out(mdc), .mdio_out(sd), .mdio_oe_out(soe));
  task automatic w(input logic [4:0] ra, input logic [15:0] v);
    logic [16:0] d;
    sta.xfer(MDMIA_OP_WRITE, own, ra, v, d);
  endtask
  task automatic r(input logic [4:0] pa, input logic [4:0] ra, input logic [16:0] e);
    logic [16:0] d;
    sta.xfer(MDMIA_OP_READ, pa, ra, 16'h0000, d);
    `CHK("read word", e, d)
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #400000;
    fail_count++;
    $display("watchdog expired");
    final_report();
  end
  initial
  begin
    rst = 1'b1;
    strap = 4'h5;
    fail_count = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    w(c, 16'h001f);
    r(own, c, 17'h0001f);
    r(own, 5'h00, 17'h00000);
    r(5'h06, c, 17'h1ffff);
    r(5'h15, c, 17'h1ffff);
    w(a, 16'h0004);
    r(own, a, 17'h00004);
    $display("test direct and address done");
    w(c, 16'h801f);
    w(a, 16'h1111);
    w(a, 16'h2222);
    w(c, 16'h001f);
    r(own, a, 17'h00006);
    w(a, 16'h0004);
    w(c, 16'h801f);
    r(own, a, 17'h01111);
    r(own, a, 17'h02222);
    w(c, 16'h001f);
    r(own, a, 17'h00006);
    $display("test increment both done");
    w(a, 16'h0004);
    w(c, 16'h401f);
    r(own, a, 17'h01111);
    w(a, 16'h5555);
    r(own, a, 17'h05555);
    w(c, 16'hc01f);
    r(own, a, 17'h05555);
    w(a, 16'h3333);
    r(own, a, 17'h02222);
    $display("test plain and write increment done");
    w(c, 16'h0001);
    w(a, 16'h0004);
    w(c, 16'h4001);
    w(a, 16'h7777);
    r(own, a, 17'h07777);
    w(c, 16'h001f);
    w(a, 16'h0004);
    w(c, 16'h401f);
    r(own, a, 17'h03333);
    w(c, 16'h0002);
    w(a, 16'h0009);
    w(c, 16'h4002);
    w(a, 16'hdead);
    r(own, a, 17'h00000);
    w(c, 16'h401f);
    r(own, a, 17'h03333);
    sta.xfer(MDMIA_OP_WRITE, 5'h06, c, 16'h0002, junk);
    sta.xfer(2'h3, own, c, 16'h0002, junk);
    r(own, c, 17'h0401f);
    $display("test select codes done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    r(own, c, 17'h00000);
    $display("test second reset done");
    final_report();
  end
endmodule
